// ### logic/alarm_pkg.sv
package alarm_pkg;

   // Alarm status word bit positions; decimal weight is two to the position.
   localparam int ALM_W          = 32;
   localparam int ALM_FPGA       = 0;
   localparam int ALM_PLL        = 1;
   localparam int ALM_FLASH      = 2;
   localparam int ALM_ACQ_FAIL   = 3;
   localparam int ALM_NO_EXT_OSC = 4;
   localparam int ALM_HEATER     = 5;
   localparam int ALM_FIRMWARE   = 6;
   localparam int ALM_TEMP_WARN  = 16;
   localparam int ALM_NO_PULSE   = 17;
   localparam int ALM_TRIM_RANGE = 18;
   localparam logic [31:0] ALM_USED_MASK = 32'h0007_007F;
   localparam logic [31:0] ALM_RESET     = 32'h0000_0000;

   // Synchronised condition vector, one bit per detector input.
   localparam int IN_W          = 13;
   localparam int IN_FPGA       = 0;
   localparam int IN_PLL        = 1;
   localparam int IN_FLASH      = 2;
   localparam int IN_ACQ_FAIL   = 3;
   localparam int IN_OSC_EXPECT = 4;
   localparam int IN_OSC_SEEN   = 5;
   localparam int IN_HEATER     = 6;
   localparam int IN_FIRMWARE   = 7;
   localparam int IN_TEMP       = 8;
   localparam int IN_LOCKED     = 9;
   localparam int IN_DISC_EN    = 10;
   localparam int IN_PULSE_SEEN = 11;
   localparam int IN_TRIM_OUT   = 12;
   localparam int SYNC_LAT      = 3;

   // Parameter attribute word layout.
   localparam int ATTR_READ_ONLY = 2;
   localparam int ATTR_SILENT    = 3;
   localparam int ATTR_PERSISTED = 5;
   localparam int ATTR_UNITS_LSB = 10;
   localparam int ATTR_UNITS_MSB = 14;
   localparam int UNITS_W        = 5;
   localparam logic [31:0] ATTR_RESET = 32'h0000_0000;

   typedef enum logic [4:0] {
      UNIT_NONE      = 5'h00,
      UNIT_PS        = 5'h01,
      UNIT_NS        = 5'h02,
      UNIT_US        = 5'h03,
      UNIT_MS        = 5'h04,
      UNIT_S         = 5'h05,
      UNIT_UV        = 5'h06,
      UNIT_MV        = 5'h07,
      UNIT_UA        = 5'h08,
      UNIT_MA        = 5'h09,
      UNIT_MDEG_C    = 5'h0A,
      UNIT_PPT       = 5'h0B,
      UNIT_PPQ       = 5'h0C,
      UNIT_HZ        = 5'h0D,
      UNIT_KHZ       = 5'h0E,
      UNIT_MHZ       = 5'h0F,
      UNIT_PERCENT   = 5'h10,
      UNIT_BOOLEAN   = 5'h11,
      UNIT_MM        = 5'h12,
      UNIT_MM_PER_S  = 5'h13,
      UNIT_M         = 5'h14,
      UNIT_M_PER_S   = 5'h15,
      UNIT_DEGREE    = 5'h16,
      UNIT_DBHZ      = 5'h17,
      UNIT_UDEG_C    = 5'h18,
      UNIT_DBM       = 5'h19
   } units_t;

endpackage

// ### logic/attr_if.sv
`timescale 1ns/1ns
interface attr_if;
   logic        read_only;
   logic        silent;
   logic        persisted;
   logic [4:0]  units;
   logic [31:0] word;

   modport encoder (input read_only, input silent, input persisted, input units, output word);
   modport user    (output read_only, output silent, output persisted, output units, input word);
endinterface

// ### logic/param_attr_enc.sv
`timescale 1ns/1ns
module param_attr_enc (
   // Attribute fields in, packed word out
   attr_if.encoder attr
);

   // Codes above the last defined unit have no meaning and encode as no units.
   function automatic logic [4:0] legal_units(input logic [4:0] code);
      legal_units = (code > alarm_pkg::UNIT_DBM) ? alarm_pkg::UNIT_NONE : code;
   endfunction

   always_comb
   begin
      attr.word = alarm_pkg::ATTR_RESET;
      attr.word[alarm_pkg::ATTR_READ_ONLY] = attr.read_only;
      attr.word[alarm_pkg::ATTR_SILENT]    = attr.silent;
      attr.word[alarm_pkg::ATTR_PERSISTED] = attr.persisted;
      attr.word[alarm_pkg::ATTR_UNITS_MSB:alarm_pkg::ATTR_UNITS_LSB] =
         legal_units(attr.units);
   end

endmodule // param_attr_enc

// ### logic/alarm_status_and_param_attrs.sv
// Operation
// - Read-only attribute bit 2; refuse writes.
// - Silent bit 3; suppress change reports.
// - Persisted bit 5; save on store command.
// - Units code in attribute bits 14..10.
// - Units codes 0 to 25, boolean 17.
// - Alarm word: set bit means active.
// - New alarm raises pin until cleared/acknowledged.
// - Pin high while any unacknowledged alarm.
// - Bits 0,1,2: logic, PLL, flash faults.
// - Bit 3: last lock attempt failed.
// - Bit 4: expected oscillator not detected.
// - Bit 5: cell heater hardware failure.
// - Bit 6: firmware incompatible with hardware.
// - Bit 16: temperature warning, only when locked.
// - Bit 17: disciplining on, no pulse input.
// - Bit 18: disciplining on, trim out of range.
// - Acknowledge takes OR of alarm weights.
// - Acknowledge only affects pin, not status.
`timescale 1ns/1ns
module alarm_status_and_param_attrs (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Alarm detector levels, asynchronous to mclk
   input  wire logic        hw_fault_fpga,
   input  wire logic        hw_fault_pll,
   input  wire logic        hw_fault_flash,
   input  wire logic        lock_attempt_failed,
   input  wire logic        ext_osc_expected,
   input  wire logic        ext_osc_seen,
   input  wire logic        heater_fault,
   input  wire logic        firmware_mismatch,
   input  wire logic        temp_unstable,
   input  wire logic        lock_achieved,
   input  wire logic        disciplining_en,
   input  wire logic        pulse_input_seen,
   input  wire logic        trim_out_of_range,
   // Acknowledge command from the command decoder
   input  wire logic        ack_valid,
   input  wire logic [31:0] ack_mask,
   // Attributes of the parameter currently addressed
   input  wire logic        attr_read_only,
   input  wire logic        attr_silent,
   input  wire logic        attr_persisted,
   input  wire logic [4:0]  attr_units,
   // Parameter commands from the command decoder
   input  wire logic        param_wr_req,
   input  wire logic        param_changed,
   input  wire logic        store_cmd,
   // Alarm results
   output logic             alarm_pin,
   output logic [31:0]      alarm_status_word,
   // Parameter results
   output logic [31:0]      parameter_attribute_word,
   output logic             param_wr_accept,
   output logic             param_wr_refused,
   output logic             change_report,
   output logic             flash_save
);

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   logic [alarm_pkg::IN_W-1:0] raw_in;
   logic [alarm_pkg::IN_W-1:0] meta_ff;
   logic [alarm_pkg::IN_W-1:0] cond_ff;

   assign raw_in = {trim_out_of_range, pulse_input_seen, disciplining_en, lock_achieved,
                    temp_unstable, firmware_mismatch, heater_fault, ext_osc_seen,
                    ext_osc_expected, lock_attempt_failed, hw_fault_flash, hw_fault_pll,
                    hw_fault_fpga};

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         cond_ff <= '0;
      end
      else
      begin
         meta_ff <= raw_in;
         cond_ff <= meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm status word.

   logic [31:0] nxt_status;
   logic [31:0] status_ff;

   always_comb
   begin
      nxt_status = alarm_pkg::ALM_RESET;
      nxt_status[alarm_pkg::ALM_FPGA]  = cond_ff[alarm_pkg::IN_FPGA];
      nxt_status[alarm_pkg::ALM_PLL]   = cond_ff[alarm_pkg::IN_PLL];
      nxt_status[alarm_pkg::ALM_FLASH] = cond_ff[alarm_pkg::IN_FLASH];
      nxt_status[alarm_pkg::ALM_ACQ_FAIL] = cond_ff[alarm_pkg::IN_ACQ_FAIL];
      nxt_status[alarm_pkg::ALM_NO_EXT_OSC] =
         cond_ff[alarm_pkg::IN_OSC_EXPECT] & ~cond_ff[alarm_pkg::IN_OSC_SEEN];
      nxt_status[alarm_pkg::ALM_HEATER]   = cond_ff[alarm_pkg::IN_HEATER];
      nxt_status[alarm_pkg::ALM_FIRMWARE] = cond_ff[alarm_pkg::IN_FIRMWARE];
      nxt_status[alarm_pkg::ALM_TEMP_WARN] =
         cond_ff[alarm_pkg::IN_TEMP] & cond_ff[alarm_pkg::IN_LOCKED];
      nxt_status[alarm_pkg::ALM_NO_PULSE] =
         cond_ff[alarm_pkg::IN_DISC_EN] & ~cond_ff[alarm_pkg::IN_PULSE_SEEN];
      // The host is expected to latch the trim when this bit rises.
      nxt_status[alarm_pkg::ALM_TRIM_RANGE] =
         cond_ff[alarm_pkg::IN_DISC_EN] & cond_ff[alarm_pkg::IN_TRIM_OUT];
   end

   // The word shows live conditions only; acknowledges never reach it.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         status_ff <= alarm_pkg::ALM_RESET;
      else
         status_ff <= nxt_status;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Acknowledge tracking and alarm pin.

   logic [31:0] ack_sel;
   logic [31:0] nxt_ack;
   logic [31:0] ack_ff;
   logic        pin_ff;

   // Only bits active now can be acknowledged, so acknowledging an idle alarm
   // cannot pre-silence a later occurrence.
   assign ack_sel = ack_valid ? (ack_mask & status_ff) : '0;
   assign nxt_ack = (ack_ff | ack_sel) & nxt_status;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         ack_ff <= '0;
      else
         ack_ff <= nxt_ack;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         pin_ff <= 1'b0;
      else
         pin_ff <= |(nxt_status & ~nxt_ack);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter attribute word and access decisions.

   attr_if attr_bus ();

   assign attr_bus.read_only = attr_read_only;
   assign attr_bus.silent    = attr_silent;
   assign attr_bus.persisted = attr_persisted;
   assign attr_bus.units     = attr_units;

   param_attr_enc u_attr_enc (
      .attr (attr_bus.encoder)
   );

   logic [31:0] attr_word_ff;
   logic        wr_accept_ff;
   logic        wr_refused_ff;
   logic        report_ff;
   logic        save_ff;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         attr_word_ff <= alarm_pkg::ATTR_RESET;
      else
         attr_word_ff <= attr_bus.word;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wr_accept_ff  <= 1'b0;
         wr_refused_ff <= 1'b0;
      end
      else
      begin
         wr_accept_ff  <= param_wr_req & ~attr_bus.word[alarm_pkg::ATTR_READ_ONLY];
         wr_refused_ff <= param_wr_req & attr_bus.word[alarm_pkg::ATTR_READ_ONLY];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         report_ff <= 1'b0;
      else
         report_ff <= param_changed & ~attr_bus.word[alarm_pkg::ATTR_SILENT];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         save_ff <= 1'b0;
      else
         save_ff <= store_cmd & attr_bus.word[alarm_pkg::ATTR_PERSISTED];
   end

   assign alarm_pin                = pin_ff;
   assign alarm_status_word        = status_ff;
   assign parameter_attribute_word = attr_word_ff;
   assign param_wr_accept          = wr_accept_ff;
   assign param_wr_refused         = wr_refused_ff;
   assign change_report            = report_ff;
   assign flash_save               = save_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   // Counts edges since reset release so that checks spanning the
   // synchroniser only start once its pipeline holds real samples.
   logic [1:0] up_cnt_ff;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         up_cnt_ff <= 2'h0;
      else if (up_cnt_ff != 2'h3)
         up_cnt_ff <= up_cnt_ff + 2'h1;
   end

   property p_read_only_refused;
      @(posedge mclk) disable iff (!rst_n)
      param_wr_req && attr_read_only |=> param_wr_refused && !param_wr_accept;
   endproperty
   a_read_only_refused: assert property (p_read_only_refused)
      else $error("write to read-only parameter was not refused");

   property p_silent_unreported;
      @(posedge mclk) disable iff (!rst_n)
      param_changed |=> change_report == !$past(attr_silent);
   endproperty
   a_silent_unreported: assert property (p_silent_unreported)
      else $error("change report does not follow the silent attribute");

   property p_persist_saved;
      @(posedge mclk) disable iff (!rst_n)
      store_cmd |=> flash_save == $past(attr_persisted);
   endproperty
   a_persist_saved: assert property (p_persist_saved)
      else $error("flash save does not follow the persisted attribute");

   property p_units_field;
      @(posedge mclk) disable iff (!rst_n)
      attr_units <= 5'h19 |=> parameter_attribute_word[14:10] == $past(attr_units)
                              && parameter_attribute_word[2] == $past(attr_read_only);
   endproperty
   a_units_field: assert property (p_units_field)
      else $error("units field misplaced in attribute word");

   property p_units_legal;
      @(posedge mclk) disable iff (!rst_n)
      parameter_attribute_word[14:10] <= 5'h19;
   endproperty
   a_units_legal: assert property (p_units_legal)
      else $error("units code above 25");

   property p_fpga_follows;
      @(posedge mclk) disable iff (!rst_n)
      up_cnt_ff == 2'h3 |-> alarm_status_word[0] == $past(hw_fault_fpga, 3);
   endproperty
   a_fpga_follows: assert property (p_fpga_follows)
      else $error("logic fault bit does not follow its input");

   property p_acq_follows;
      @(posedge mclk) disable iff (!rst_n)
      up_cnt_ff == 2'h3 |-> alarm_status_word[3] == $past(lock_attempt_failed, 3);
   endproperty
   a_acq_follows: assert property (p_acq_follows)
      else $error("acquisition failed bit does not follow its input");

   property p_ext_osc;
      @(posedge mclk) disable iff (!rst_n)
      up_cnt_ff == 2'h3 |->
         alarm_status_word[4] == ($past(ext_osc_expected, 3) && !$past(ext_osc_seen, 3));
   endproperty
   a_ext_osc: assert property (p_ext_osc)
      else $error("missing oscillator bit wrong");

   property p_temp_locked;
      @(posedge mclk) disable iff (!rst_n)
      alarm_status_word[16] |-> $past(lock_achieved, 3);
   endproperty
   a_temp_locked: assert property (p_temp_locked)
      else $error("temperature warning raised while unlocked");
   property p_no_pulse;
      @(posedge mclk) disable iff (!rst_n)
      up_cnt_ff == 2'h3 |->
         alarm_status_word[17] == ($past(disciplining_en, 3) && !$past(pulse_input_seen, 3));
   endproperty
   a_no_pulse: assert property (p_no_pulse)
      else $error("missing pulse bit wrong");
   property p_trim_range;
      @(posedge mclk) disable iff (!rst_n)
      alarm_status_word[18] |-> $past(disciplining_en, 3) && $past(trim_out_of_range, 3);
   endproperty
   a_trim_range: assert property (p_trim_range)
      else $error("range warning without disciplining");
   property p_unused_zero;
      @(posedge mclk) disable iff (!rst_n)
      (alarm_status_word & 32'hFFF8_FF80) == 32'h0000_0000
      && (parameter_attribute_word & 32'hFFFF_83D3) == 32'h0000_0000;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused bit reads non-zero");
   property p_pin_tracks;
      @(posedge mclk) disable iff (!rst_n)
      !$past(ack_valid) && $stable(alarm_status_word) |-> $stable(alarm_pin);
   endproperty
   a_pin_tracks: assert property (p_pin_tracks)
      else $error("alarm pin moved with no acknowledge and no alarm change");
   property p_new_alarm_raises;
      @(posedge mclk) disable iff (!rst_n)
      (alarm_status_word & ~$past(alarm_status_word)) != 32'h0000_0000 |-> alarm_pin;
   endproperty
   a_new_alarm_raises: assert property (p_new_alarm_raises)
      else $error("new alarm did not raise the pin");
   property p_ack_applied;
      @(posedge mclk) disable iff (!rst_n)
      ack_valid && (ack_mask & alarm_status_word) == alarm_status_word
      ##1 $stable(alarm_status_word) |-> !alarm_pin;
   endproperty
   a_ack_applied: assert property (p_ack_applied)
      else $error("acknowledge of all active alarms left the pin high");
   property p_ack_keeps_status;
      @(posedge mclk) disable iff (!rst_n)
      ack_valid && up_cnt_ff == 2'h3 |=> alarm_status_word[0] == $past(hw_fault_fpga, 3)
         && alarm_status_word[2] == $past(hw_fault_flash, 3)
         && alarm_status_word[3] == $past(lock_attempt_failed, 3);
   endproperty
   a_ack_keeps_status: assert property (p_ack_keeps_status)
      else $error("acknowledge altered the status word");
   property p_ack_dropped;
      @(posedge mclk) disable iff (!rst_n)
      (ack_ff & ~alarm_status_word) == 32'h0000_0000;
   endproperty
   a_ack_dropped: assert property (p_ack_dropped)
      else $error("acknowledge kept for a cleared alarm");
   property p_status_live;
      @(posedge mclk) disable iff (!rst_n)
      up_cnt_ff == 2'h3 |-> alarm_status_word[5] == $past(heater_fault, 3)
                            && alarm_status_word[6] == $past(firmware_mismatch, 3);
   endproperty
   a_status_live: assert property (p_status_live)
      else $error("heater or firmware bit stale");
   c_ack_silences: cover property (@(posedge mclk) disable iff (!rst_n)
      alarm_pin ##1 ack_valid ##1 !alarm_pin && alarm_status_word != 32'h0000_0000);
   c_recur_raises: cover property (@(posedge mclk) disable iff (!rst_n)
      ack_ff[0] ##1 !alarm_status_word[0] ##[1:20] alarm_pin && alarm_status_word[0]);
   c_two_alarms: cover property (@(posedge mclk) disable iff (!rst_n)
      alarm_status_word[1] && alarm_status_word[18] && alarm_pin);
   c_refused: cover property (@(posedge mclk) disable iff (!rst_n) param_wr_refused);

endmodule // alarm_status_and_param_attrs

// ### bench/host_model.sv
`timescale 1ns/1ns
module host_model (
   // Clock
   input  wire logic        mclk,
   // Alarm view
   input  wire logic [31:0] alarm_status_word,
   // Acknowledge command
   output logic             ack_valid,
   output logic [31:0]      ack_mask
);
   int   latch_count;
   logic range_seen;

   initial
   begin
      ack_valid   = 1'b0;
      ack_mask    = 32'h0000_0000;
      latch_count = 0;
      range_seen  = 1'b0;
   end

   // A real host would issue a latch here; the count lets a test see that it did.
   always @(posedge mclk)
   begin
      if (alarm_status_word[alarm_pkg::ALM_TRIM_RANGE] === 1'b1 && !range_seen)
      begin
         latch_count++;
      end
      range_seen <= (alarm_status_word[alarm_pkg::ALM_TRIM_RANGE] === 1'b1);
   end

   // The mask is inverted on release so that a stale value is never mistaken for a command.
   task automatic send_ack(input logic [31:0] m);
      @(negedge mclk);
      ack_valid = 1'b1;
      ack_mask  = m;
      @(negedge mclk);
      ack_valid = 1'b0;
      ack_mask  = ~m;
   endtask
endmodule // host_model

// ### bench/alarm_status_and_param_attrs_bench.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("[FAIL] t=%0t got %h expected %h", $time, (got), (exp)); \
      end \
   end
module alarm_status_and_param_attrs_bench;
   logic        mclk;
   logic        rst_n;
   logic [12:0] cond;
   logic        ack_valid;
   logic [31:0] ack_mask;
   logic        attr_read_only;
   logic        attr_silent;
   logic        attr_persisted;
   logic [4:0]  attr_units;
   logic        param_wr_req;
   logic        param_changed;
   logic        store_cmd;
   logic        alarm_pin;
   logic [31:0] alarm_status_word;
   logic [31:0] parameter_attribute_word;
   logic        param_wr_accept;
   logic        param_wr_refused;
   logic        change_report;
   logic        flash_save;
   int          mismatches;
   int          check_count;
   logic [31:0] exp_attr;

   alarm_status_and_param_attrs u_alarm_status_and_param_attrs (
      .mclk                     (mclk),
      .rst_n                    (rst_n),
      .hw_fault_fpga            (cond[alarm_pkg::IN_FPGA]),
      .hw_fault_pll             (cond[alarm_pkg::IN_PLL]),
      .hw_fault_flash           (cond[alarm_pkg::IN_FLASH]),
      .lock_attempt_failed      (cond[alarm_pkg::IN_ACQ_FAIL]),
      .ext_osc_expected         (cond[alarm_pkg::IN_OSC_EXPECT]),
      .ext_osc_seen             (cond[alarm_pkg::IN_OSC_SEEN]),
      .heater_fault             (cond[alarm_pkg::IN_HEATER]),
      .firmware_mismatch        (cond[alarm_pkg::IN_FIRMWARE]),
      .temp_unstable            (cond[alarm_pkg::IN_TEMP]),
      .lock_achieved            (cond[alarm_pkg::IN_LOCKED]),
      .disciplining_en          (cond[alarm_pkg::IN_DISC_EN]),
      .pulse_input_seen         (cond[alarm_pkg::IN_PULSE_SEEN]),
      .trim_out_of_range        (cond[alarm_pkg::IN_TRIM_OUT]),
      .ack_valid                (ack_valid),
      .ack_mask                 (ack_mask),
      .attr_read_only           (attr_read_only),
      .attr_silent              (attr_silent),
      .attr_persisted           (attr_persisted),
      .attr_units               (attr_units),
      .param_wr_req             (param_wr_req),
      .param_changed            (param_changed),
      .store_cmd                (store_cmd),
      .alarm_pin                (alarm_pin),
      .alarm_status_word        (alarm_status_word),
      .parameter_attribute_word (parameter_attribute_word),
      .param_wr_accept          (param_wr_accept),
      .param_wr_refused         (param_wr_refused),
      .change_report            (change_report),
      .flash_save               (flash_save)
   );

   host_model u_host_model (
      .mclk              (mclk),
      .alarm_status_word (alarm_status_word),
      .ack_valid         (ack_valid),
      .ack_mask          (ack_mask)
   );

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [12:0] b(input int i);
      return 13'h0001 << i;
   endfunction

   // Two edges through the synchroniser, one more to land the result, one spare.
   task automatic settle(input logic [12:0] v);
      cond = v;
      repeat (4) @(negedge mclk);
   endtask

   task automatic try(input logic [12:0] v, input logic [31:0] w);
      settle(v);
      `CHK(alarm_status_word, w)
      `CHK(alarm_pin, |w)
      settle(13'h0000);
      `CHK(alarm_status_word, 32'h0000_0000)
      `CHK(alarm_pin, 1'b0)
   endtask

   task automatic ack_check(input logic [31:0] m, input logic pin, input logic [31:0] w);
      u_host_model.send_ack(m);
      @(negedge mclk);
      `CHK(alarm_pin, pin)
      `CHK(alarm_status_word, w)
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      #100000;
      mismatches++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mismatches = 0;
      check_count = 0;
      rst_n = 1'b0;
      cond = 13'h0000;
      {attr_read_only, attr_silent, attr_persisted, attr_units} = 8'h00;
      {param_wr_req, param_changed, store_cmd} = 3'h0;
      repeat (2) @(negedge mclk);
      `CHK({alarm_pin, alarm_status_word, parameter_attribute_word}, 65'h0)
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);

      try(b(alarm_pkg::IN_FPGA), 32'h0000_0001);
      try(b(alarm_pkg::IN_PLL), 32'h0000_0002);
      try(b(alarm_pkg::IN_FLASH), 32'h0000_0004);
      try(b(alarm_pkg::IN_ACQ_FAIL), 32'h0000_0008);
      try(b(alarm_pkg::IN_OSC_EXPECT), 32'h0000_0010);
      try(b(alarm_pkg::IN_OSC_EXPECT) | b(alarm_pkg::IN_OSC_SEEN), 32'h0000_0000);
      try(b(alarm_pkg::IN_HEATER), 32'h0000_0020);
      try(b(alarm_pkg::IN_FIRMWARE), 32'h0000_0040);
      try(b(alarm_pkg::IN_TEMP), 32'h0000_0000);
      try(b(alarm_pkg::IN_TEMP) | b(alarm_pkg::IN_LOCKED), 32'h0001_0000);
      try(b(alarm_pkg::IN_DISC_EN), 32'h0002_0000);
      try(b(alarm_pkg::IN_PULSE_SEEN) | b(alarm_pkg::IN_DISC_EN), 32'h0000_0000);
      try(b(alarm_pkg::IN_TRIM_OUT) | b(alarm_pkg::IN_PULSE_SEEN), 32'h0000_0000);
      try(b(alarm_pkg::IN_TRIM_OUT) | b(10) | b(11), 32'h0004_0000);
      `CHK(u_host_model.latch_count, 1)
      $display("alarm bit test done");

      settle(b(alarm_pkg::IN_FPGA) | b(alarm_pkg::IN_FLASH));
      `CHK(alarm_pin, 1'b1)
      ack_check(32'h0000_0001, 1'b1, 32'h0000_0005);
      // Unused and inactive bits ride along; none of them may pre-acknowledge.
      ack_check(32'hFFFF_FFFC, 1'b0, 32'h0000_0005);
      settle(b(alarm_pkg::IN_FPGA) | b(alarm_pkg::IN_FLASH) | b(alarm_pkg::IN_ACQ_FAIL));
      `CHK(alarm_pin, 1'b1)
      ack_check(32'h0000_0008, 1'b0, 32'h0000_000D);
      settle(b(alarm_pkg::IN_FLASH) | b(alarm_pkg::IN_ACQ_FAIL));
      `CHK({alarm_pin, alarm_status_word}, 33'h0_0000_000C)
      settle(b(alarm_pkg::IN_FPGA) | b(alarm_pkg::IN_FLASH) | b(alarm_pkg::IN_ACQ_FAIL));
      `CHK(alarm_pin, 1'b1)
      ack_check(32'h0000_000D, 1'b0, 32'h0000_000D);
      settle(13'h0000);
      `CHK({alarm_pin, alarm_status_word}, 33'h0_0000_0000)
      $display("acknowledge test done");

      for (int u = 0; u < 32; u++)
      begin
         {attr_persisted, attr_silent, attr_read_only} = 3'(u);
         attr_units = 5'(u);
         {param_wr_req, param_changed, store_cmd} = 3'h7;
         exp_attr = {17'h0_0000, (u > 25) ? 5'h00 : 5'(u), 4'h0, attr_persisted, 1'b0,
                     attr_silent, attr_read_only, 2'h0};
         @(negedge mclk);
         {param_wr_req, param_changed, store_cmd} = 3'h0;
         `CHK(parameter_attribute_word, exp_attr)
         `CHK({param_wr_accept, param_wr_refused}, {~attr_read_only, attr_read_only})
         `CHK(change_report, ~attr_silent)
         `CHK(flash_save, attr_persisted)
         if (u == 17)
            `CHK(parameter_attribute_word, 32'h0000_4404)
         @(negedge mclk);
         `CHK({param_wr_accept, param_wr_refused, change_report, flash_save}, 4'h0)
      end
      $display("attribute test done");
      close_out();
   end
endmodule // alarm_status_and_param_attrs_bench
